// ==== hdl/emi_params.svh ====
`ifndef EMI_PARAMS_SVH
`define EMI_PARAMS_SVH
// ----------------------------------------
// register byte offsets (apb)
// ----------------------------------------
`define CFG_OFF 12'h000
`define PAGE_OFF 12'h004
`define TIMING_OFF 12'h008
`define STATUS_OFF 12'h00c
// ----------------------------------------
// reset values
// ----------------------------------------
`define CFG_RESET 8'h03
`define PAGE_RESET 8'h00
`define TIMING_RESET 8'hff
// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_MUX_BIT 4
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2
`define CFG_ALE_HI 1
`define CFG_ALE_LO 0
`define TC_SETUP_HI 7
`define TC_SETUP_LO 6
`define TC_STROBE_HI 5
`define TC_STROBE_LO 2
`define TC_HOLD_HI 1
`define TC_HOLD_LO 0
// ----------------------------------------
// memory modes and map
// ----------------------------------------
`define MODE_ONCHIP 2'b00
`define MODE_SPLIT 2'b01
`define MODE_BANK 2'b10
`define MODE_EXT 2'b11
`define ONCHIP_TOP 16'h1000
// ----------------------------------------
// fixed overhead of an off-chip access
// ----------------------------------------
`define FIXED_CYCLES 6'h04
`define TAIL_CNT 4'h2
`endif

// ==== hdl/emi_pkg.sv ====
`default_nettype none
package emi_pkg;
	// access states
	typedef enum logic [2:0] {
		ST_IDLE, ST_ONCHIP, ST_START, ST_ALE_HI, ST_ALE_LO,
		ST_SETUP, ST_STROBE, ST_TAIL_OR_HOLD
	} emi_state_t;
	// one external-move request from the cpu
	typedef struct packed {
		logic is16;
		logic wr;
		logic [7:0] idx;
		logic [15:0] data_pointer_pair;
		logic [7:0] wdata;
	} cpu_req_t;
	// external bus pin outputs
	typedef struct packed {
		logic [7:0] ad_o;
		logic ad_oe;
		logic [7:0] addr_lo_o;
		logic addr_lo_oe;
		logic [7:0] addr_hi_o;
		logic addr_hi_oe;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic pins_own;
	} pin_out_t;
endpackage
`default_nettype wire

// ==== hdl/external_data_memory_interface.sv ====
// How it works
// - cfg bit 4 selects multiplexed or separate pins
// - muxed mode shares data and low address
// - device drives the address latch strobe
// - strobe high phase shows low address
// - muxed data phase carries data at strobe
// - non-muxed uses separate pins, no latch phase
// - mode 00 goes on-chip, wraps at 4k
// - 8-bit address is page plus index byte
// - 16-bit address comes from data pointer
// - modes 01/10 split at 4k boundary
// - split mode 8-bit leaves upper pins alone
// - off-chip 16-bit drives all sixteen pins
// - bank mode upper byte from page
// - mode 11 all off-chip, upper undriven in 8-bit access
// - access is timing plus four cycles
// - muxed adds two or more latch cycles
// - timing register resets to all ones
// - timing fields setup, width, hold layout
// - strobe width is field plus one
// - pins owned only during off-chip access
// - input pins are not driven
`include "emi_params.svh"
`default_nettype none
module external_data_memory_interface
	import emi_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu external-move port
	input wire logic cpu_req,
	input wire cpu_req_t cpu_cmd,
	output logic cpu_ready,
	output logic cpu_ack,
	output logic [7:0] cpu_rdata,
	// on-chip expansion ram (read data valid with enable)
	output logic on_chip_expansion_ram_en,
	output logic on_chip_expansion_ram_we,
	output logic [11:0] on_chip_expansion_ram_addr,
	output logic [7:0] on_chip_expansion_ram_wdata,
	input wire logic [7:0] on_chip_expansion_ram_rdata,
	// external memory pins
	input wire logic [7:0] ad_i,
	output pin_out_t pins
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] cfg_ff;
	logic [7:0] page_ff;
	logic [7:0] timing_ff;
	logic [31:0] prdata_ff;
	logic [1:0] mode;
	logic nonmux;
	logic [1:0] setup_f;
	logic [3:0] strobe_f;
	logic [1:0] hold_f;
	logic [1:0] ale_f;

	assign mode = cfg_ff[`CFG_MODE_HI:`CFG_MODE_LO];
	assign nonmux = cfg_ff[`CFG_MUX_BIT];
	assign setup_f = timing_ff[`TC_SETUP_HI:`TC_SETUP_LO];
	assign strobe_f = timing_ff[`TC_STROBE_HI:`TC_STROBE_LO];
	assign hold_f = timing_ff[`TC_HOLD_HI:`TC_HOLD_LO];
	assign ale_f = cfg_ff[`CFG_ALE_HI:`CFG_ALE_LO];

	// ----------------------------------------
	// access state
	// ----------------------------------------
	emi_state_t state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic in_hold_ff, nxt_in_hold;
	logic [15:0] addr_ff;
	logic [7:0] wdata_ff;
	logic wr_ff;
	logic mux_ff;
	logic hi_drive_ff;
	logic ack_ff;
	logic [7:0] rdata_ff;
	logic [7:0] sync1_ff, sync2_ff, sync3_ff;
	logic [2:0] samp_ff;
	logic [15:0] eff_addr;
	logic take;

	// is the effective address served on-chip
	function automatic logic is_onchip(input logic [1:0] m, input logic [15:0] a);
		is_onchip = (m == `MODE_ONCHIP) || ((m != `MODE_EXT) && (a < `ONCHIP_TOP));
	endfunction

	// ----------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------
	logic wr_acc;
	logic mapped;
	assign wr_acc = psel && penable && pwrite;
	assign mapped = (paddr == `CFG_OFF) || (paddr == `PAGE_OFF) ||
		(paddr == `TIMING_OFF) || (paddr == `STATUS_OFF);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_ff;

	// configuration register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= `CFG_RESET;
		end else if (wr_acc && paddr == `CFG_OFF) begin
			cfg_ff <= {2'h0, pwdata[5:0]};
		end
	end

	// page register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_ff <= `PAGE_RESET;
		end else if (wr_acc && paddr == `PAGE_OFF) begin
			page_ff <= pwdata[7:0];
		end
	end

	// timing register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timing_ff <= `TIMING_RESET;
		end else if (wr_acc && paddr == `TIMING_OFF) begin
			timing_ff <= pwdata[7:0];
		end
	end

	// read data loaded in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
		end else if (psel && !penable) begin
			unique case (paddr)
				`CFG_OFF: prdata_ff <= {24'h0, cfg_ff};
				`PAGE_OFF: prdata_ff <= {24'h0, page_ff};
				`TIMING_OFF: prdata_ff <= {24'h0, timing_ff};
				`STATUS_OFF: prdata_ff <= {16'h0, rdata_ff, 6'h0, pins.pins_own, state_ff != ST_IDLE};
				default: prdata_ff <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	assign cpu_ready = (state_ff == ST_IDLE);
	assign take = cpu_req && cpu_ready;
	assign eff_addr = cpu_cmd.is16 ? cpu_cmd.data_pointer_pair : {page_ff, cpu_cmd.idx};

	// capture the request when taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_ff <= 16'h0;
			wdata_ff <= 8'h0;
			wr_ff <= 1'b0;
			mux_ff <= 1'b0;
			hi_drive_ff <= 1'b0;
		end else if (take) begin
			addr_ff <= eff_addr;
			wdata_ff <= cpu_cmd.wdata;
			wr_ff <= cpu_cmd.wr;
			mux_ff <= !nonmux;
			hi_drive_ff <= cpu_cmd.is16 || (mode == `MODE_BANK);
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_in_hold = in_hold_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_state = is_onchip(mode, eff_addr) ? ST_ONCHIP : ST_START;
				end
			end
			ST_ONCHIP: begin
				nxt_state = ST_IDLE;
			end
			ST_START: begin
				if (mux_ff) begin
					nxt_state = ST_ALE_HI;
					nxt_cnt = {2'h0, ale_f};
				end else if (setup_f == 2'h0) begin
					nxt_state = ST_STROBE;
					nxt_cnt = strobe_f;
				end else begin
					nxt_state = ST_SETUP;
					nxt_cnt = {2'h0, setup_f - 2'h1};
				end
			end
			ST_ALE_HI: begin
				if (cnt_ff == 4'h0) begin
					nxt_state = ST_ALE_LO;
					nxt_cnt = {2'h0, ale_f};
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			ST_ALE_LO: begin
				if (cnt_ff != 4'h0) begin
					nxt_cnt = cnt_ff - 4'h1;
				end else if (setup_f == 2'h0) begin
					nxt_state = ST_STROBE;
					nxt_cnt = strobe_f;
				end else begin
					nxt_state = ST_SETUP;
					nxt_cnt = {2'h0, setup_f - 2'h1};
				end
			end
			ST_SETUP: begin
				if (cnt_ff == 4'h0) begin
					nxt_state = ST_STROBE;
					nxt_cnt = strobe_f;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			ST_STROBE: begin
				if (cnt_ff != 4'h0) begin
					nxt_cnt = cnt_ff - 4'h1;
				end else begin
					nxt_state = ST_TAIL_OR_HOLD;
					nxt_in_hold = (hold_f != 2'h0);
					nxt_cnt = (hold_f != 2'h0) ? {2'h0, hold_f - 2'h1} : `TAIL_CNT;
				end
			end
			ST_TAIL_OR_HOLD: begin
				if (cnt_ff != 4'h0) begin
					nxt_cnt = cnt_ff - 4'h1;
				end else if (in_hold_ff) begin
					nxt_in_hold = 1'b0;
					nxt_cnt = `TAIL_CNT;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			in_hold_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			in_hold_ff <= nxt_in_hold;
		end
	end

	// ----------------------------------------
	// read data path
	// ----------------------------------------
	// pin data passes three flops; the first holds the last strobe sample, so stages two and three agree
	// on it even though the released pins change right after the strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 8'h0;
			sync2_ff <= 8'h0;
			sync3_ff <= 8'h0;
			samp_ff <= 3'h0;
		end else begin
			if (state_ff == ST_STROBE && !wr_ff) begin
				sync1_ff <= ad_i;
			end
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			samp_ff <= {samp_ff[1:0], state_ff == ST_STROBE && cnt_ff == 4'h0 && !wr_ff};
		end
	end

	// answer to the cpu
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_ff <= 1'b0;
			rdata_ff <= 8'h0;
		end else begin
			ack_ff <= (state_ff == ST_ONCHIP) ||
				(state_ff == ST_TAIL_OR_HOLD && !in_hold_ff && cnt_ff == 4'h0);
			if (state_ff == ST_ONCHIP && !wr_ff) begin
				rdata_ff <= on_chip_expansion_ram_rdata;
			end else if (samp_ff[2] && sync2_ff == sync3_ff) begin
				rdata_ff <= sync3_ff; // value at the strobe's last cycle
			end
		end
	end
	assign cpu_ack = ack_ff;
	assign cpu_rdata = rdata_ff;

	// ----------------------------------------
	// on-chip ram port
	// ----------------------------------------
	assign on_chip_expansion_ram_en = (state_ff == ST_ONCHIP);
	assign on_chip_expansion_ram_we = on_chip_expansion_ram_en && wr_ff;
	assign on_chip_expansion_ram_addr = addr_ff[11:0];
	assign on_chip_expansion_ram_wdata = wdata_ff;

	// ----------------------------------------
	// pin drive, decoded from flops
	// ----------------------------------------
	logic offchip;
	logic ale_ph;
	logic strobe_ph;
	assign offchip = (state_ff != ST_IDLE) && (state_ff != ST_ONCHIP);
	assign ale_ph = (state_ff == ST_ALE_HI);
	assign strobe_ph = (state_ff == ST_STROBE);
	always_comb begin
		pins.pins_own = offchip;
		pins.ale = ale_ph;
		pins.rd_n = !(strobe_ph && !wr_ff);
		pins.wr_n = !(strobe_ph && wr_ff);
		pins.addr_hi_o = addr_ff[15:8];
		pins.addr_hi_oe = offchip && hi_drive_ff;
		pins.addr_lo_o = addr_ff[7:0];
		pins.addr_lo_oe = offchip && !mux_ff;
		pins.ad_o = (mux_ff && ale_ph) ? addr_ff[7:0] : wdata_ff;
		pins.ad_oe = offchip && ((mux_ff && ale_ph) || wr_ff);
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [5:0] len_ff;
	logic [4:0] strb_len_ff;
	logic strb;
	assign strb = !pins.rd_n || !pins.wr_n;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			len_ff <= 6'h0;
			strb_len_ff <= 5'h0;
		end else begin
			len_ff <= (state_ff == ST_START) ? 6'h1 : (offchip ? len_ff + 6'h1 : len_ff);
			strb_len_ff <= strb ? strb_len_ff + 5'h1 : 5'h0;
		end
	end

	access_length_a: assert property (cpu_ack && $past(offchip) && $stable(timing_ff) |->
		len_ff == {4'h0, setup_f} + {2'h0, strobe_f} + 6'h1 + {4'h0, hold_f} + `FIXED_CYCLES +
		(mux_ff ? {3'h0, ale_f, 1'b0} + 6'h2 : 6'h0))
		else $error("off-chip access length wrong");
	strobe_width_a: assert property ($fell(strb) && $stable(timing_ff) |->
		strb_len_ff == {1'b0, strobe_f} + 5'h1)
		else $error("strobe width wrong");
	no_ale_nonmux_a: assert property (pins.addr_lo_oe |-> !pins.ale)
		else $error("latch strobe in non-muxed mode");
	ale_addr_a: assert property (pins.ale |-> pins.ad_oe && pins.ad_o == addr_ff[7:0])
		else $error("low address missing in latch phase");
	ale_then_low_a: assert property ($fell(pins.ale) |-> !pins.ale [*1] ##0 pins.pins_own)
		else $error("latch phase ended badly");
	write_data_a: assert property (!pins.wr_n |-> pins.ad_oe && pins.ad_o == wdata_ff)
		else $error("write data not driven at strobe");
	read_undriven_a: assert property (!pins.rd_n |-> !pins.ad_oe)
		else $error("data driven during read");
	pins_released_a: assert property (!pins.pins_own |-> pins.rd_n && pins.wr_n && !pins.ad_oe)
		else $error("pins driven outside access");
	onchip_quiet_a: assert property (on_chip_expansion_ram_en |-> !pins.pins_own ##1 cpu_ack)
		else $error("on-chip access touched pins");
	bank_upper_a: assert property (take && !cpu_cmd.is16 && mode == `MODE_BANK && page_ff >= 8'h10
		##1 1'b1 |-> ##1 pins.addr_hi_oe && pins.addr_hi_o == $past(page_ff, 2))
		else $error("bank upper byte wrong");
	ext_upper_a: assert property (take && !cpu_cmd.is16 && mode == `MODE_EXT |=>
		##1 !pins.addr_hi_oe)
		else $error("upper pins driven in 8-bit access");

	mux_read_c: cover property (pins.ale ##[1:20] !pins.rd_n);
	nonmux_write_c: cover property (pins.addr_lo_oe && !pins.wr_n);
	onchip_c: cover property (on_chip_expansion_ram_en ##1 cpu_ack);

endmodule
`default_nettype wire

// ==== verif/ext_sram_model.sv ====
`default_nettype none
module ext_sram_model
	import emi_pkg::*;
(
	// clock
	input wire logic pclk,
	// pins from the interface and the port latches
	input wire pin_out_t pins,
	input wire logic [7:0] port_hi,
	// data back to the interface, and the decoded address for the testbench
	output logic [7:0] ad_i,
	output logic [15:0] addr
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// storage and address latch
	// ----------------------------------------
	logic [7:0] mem [0:65535];
	logic [7:0] lat_q;
	logic [7:0] wbuf;
	logic [15:0] wadr;
	logic [7:0] last_rd = 8'h00;
	logic was_wr = 1'h0;
	// transparent while the strobe is high, frozen once it falls
	always_latch begin
		if (pins.ale) lat_q <= pins.ad_o;
	end
	// undriven upper pins show what the port latches hold
	assign addr = {pins.addr_hi_oe ? pins.addr_hi_o : port_hi, pins.addr_lo_oe ? pins.addr_lo_o : lat_q};
	// released data pins never keep the last value
	assign ad_i = (pins.rd_n === 1'h0) ? mem[addr] : ~last_rd;
	// write data is taken in the last strobe cycle and stored after it
	always @(posedge pclk) begin
		if (pins.wr_n === 1'h0) begin
			wbuf <= pins.ad_o;
			wadr <= addr;
		end
		if (pins.wr_n === 1'h1 && was_wr) mem[wadr] <= wbuf;
		was_wr <= (pins.wr_n === 1'h0);
		if (pins.rd_n === 1'h0) last_rd <= mem[addr];
	end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`include "emi_params.svh"
`default_nettype none
module tb_top
	import emi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, cpu_ready, cpu_ack, on_chip_expansion_ram_en, on_chip_expansion_ram_we;
	logic cpu_req = 1'h0;
	cpu_req_t cpu_cmd = '0;
	logic [7:0] cpu_rdata, on_chip_expansion_ram_wdata, ad_i;
	logic [11:0] on_chip_expansion_ram_addr;
	logic [7:0] port_hi = 8'h00;
	logic [15:0] mem_addr;
	pin_out_t pins;
	logic mux;
	logic [1:0] mode, alef;
	logic [7:0] tc, page;
	int failures = 0;
	int n_checks = 0;
	// ----------------------------------------
	// design, memory and clock
	// ----------------------------------------
	external_data_memory_interface dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_req(cpu_req), .cpu_cmd(cpu_cmd), .cpu_ready(cpu_ready), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
		.on_chip_expansion_ram_en(on_chip_expansion_ram_en), .on_chip_expansion_ram_we(on_chip_expansion_ram_we), .on_chip_expansion_ram_addr(on_chip_expansion_ram_addr), .on_chip_expansion_ram_wdata(on_chip_expansion_ram_wdata),
		.on_chip_expansion_ram_rdata(on_chip_expansion_ram_addr[7:0] ^ 8'h5a), .ad_i(ad_i), .pins(pins));
	ext_sram_model sram (.pclk(pclk), .pins(pins), .port_hi(port_hi), .ad_i(ad_i), .addr(mem_addr));
	// free-running clock
	always #2 pclk = ~pclk;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// expected off-chip access length: timing fields plus fixed overhead, plus latch phases when muxed
	function automatic int exp_len(input logic [7:0] t, input logic m, input logic [1:0] a);
		return t[7:6] + t[5:2] + 1 + t[1:0] + 4 + (m ? 2 * (a + 1) : 0);
	endfunction
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic err);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	// one external-move access with every pin expectation
	task automatic xfer(input cpu_req_t c);
		logic [15:0] ea, pa;
		logic off, hi;
		int len, n, strb, aleh, xn;
		ea = c.is16 ? c.data_pointer_pair : {page, c.idx};
		off = (mode == 2'h3) || (mode != 2'h0 && ea >= 16'h1000);
		hi = c.is16 || mode == 2'h2;
		pa = {hi ? ea[15:8] : port_hi, ea[7:0]};
		len = exp_len(tc, mux, alef);
		cpu_cmd <= c;
		cpu_req <= 1'h1;
		do @(posedge pclk); while (cpu_ready !== 1'h1);
		cpu_req <= 1'h0;
		n = 0;
		strb = 0;
		aleh = 0;
		xn = 0;
		do begin
			@(posedge pclk);
			n++;
			if (pins.ale === 1'h1) begin
				aleh++;
				chk({pins.ad_oe, pins.ad_o}, {1'h1, ea[7:0]});
			end
			if (pins.rd_n === 1'h0 || pins.wr_n === 1'h0) begin
				strb++;
				chk({pins.pins_own, pins.ad_oe, pins.addr_hi_oe, pins.addr_lo_oe, mem_addr},
					{1'h1, c.wr, hi, !mux, pa});
				if (c.wr) chk(pins.ad_o, c.wdata);
			end
			if (on_chip_expansion_ram_en === 1'h1) begin
				xn++;
				chk({on_chip_expansion_ram_we, on_chip_expansion_ram_addr, c.wr ? on_chip_expansion_ram_wdata : c.wdata}, {c.wr, ea[11:0], c.wdata});
			end
		end while (cpu_ack !== 1'h1 && n < 80);
		chk(n, off ? len + 1 : 2);
		chk({8'(strb), 8'(aleh), 8'(xn)},
			{8'(off ? tc[5:2] + 1 : 0), 8'(off && mux ? alef + 1 : 0), 8'(!off)});
		chk({pins.pins_own, pins.ad_oe, pins.addr_hi_oe, pins.addr_lo_oe, pins.rd_n, pins.wr_n}, 6'h03);
		if (!c.wr) chk(cpu_rdata, off ? c.wdata : ea[7:0] ^ 8'h5a);
	endtask
	task automatic final_report();
		if (failures == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] q;
		logic e;
		cpu_req_t c;
		void'($urandom(32'hcbf592e4));
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, `TIMING_OFF, 32'h0, q, e);
		chk(q, 32'hff);
		apb(1'h0, `CFG_OFF, 32'h0, q, e);
		chk({e, q[30:0]}, 32'h03);
		apb(1'h0, 12'h010, 32'h0, q, e);
		chk(e, 1'h1);
		for (int i = 0; i < 48; i++) begin
			mux = 1'($urandom);
			mode = 2'(i);
			alef = 2'($urandom);
			tc = (i < 4) ? 8'h00 : (i < 8) ? 8'hff : 8'($urandom);
			page = 8'($urandom);
			port_hi <= 8'($urandom);
			apb(1'h1, `CFG_OFF, {27'h0, !mux, mode, alef}, q, e);
			apb(1'h1, `PAGE_OFF, {24'h0, page}, q, e);
			apb(1'h1, `TIMING_OFF, {24'h0, tc}, q, e);
			apb(1'h0, `TIMING_OFF, 32'h0, q, e);
			chk(q, {24'h0, tc});
			c.is16 = (i < 8) ? 1'h1 : 1'($urandom);
			c.data_pointer_pair = (i < 8) ? ((i / 4) % 2 ? 16'h1000 : 16'h0fff) : 16'($urandom);
			c.idx = 8'($urandom);
			c.wdata = 8'($urandom);
			c.wr = 1'h1;
			xfer(c);
			c.wr = 1'h0;
			xfer(c);
		end
		final_report();
	end
	// watchdog cuts a hang short
	initial begin
		#(4 * 60000);
		failures++;
		final_report();
	end
endmodule
`default_nettype wire
